// File: hdl/keyswitch_ctrl.sv
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
// Keyswitch arming, status LEDs, aux output and alarm triggers
module keyswitch_ctrl
  import keyswitch_pkg::*;
#(
  parameter int DEB = DEB_CYC, // Debounce length in cycles
  parameter longint HOLD_CYC = HOLD_CYC_DEF, // Stay-arm hold in cycles
  parameter int SLOW_FLASH = SLOW_FLASH_DEF, // Slow flash half period
  parameter int FAST_FLASH = FAST_FLASH_DEF, // Rapid flash half period
  parameter int RST_PULSE = RST_PULSE_DEF // Detector reset pulse length
) (
  input wire logic mclk, // Clock, 250 MHz
  input wire logic rst_b, // Sync reset, active low
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte enables
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic irq, // Level interrupt
  input wire logic keyswitch_in, // Keyswitch zone contact, high shorted
  input wire logic tamper_in, // Tamper zone, high when open
  input wire logic part_ready, // Keyswitch partition ready to arm
  input wire logic [NPART-1:0] keypad_sound, // Keypad sounder per partition
  input wire logic [NPART-1:0] keypad_beep, // Key acknowledge beep per partition
  output logic led_green, // Green indicator
  output logic led_red, // Red indicator
  output logic aux_out, // General-purpose output
  output logic detector_reset_b, // Two-wire detector power, low resets
  output logic trig_fire, // Fire trigger
  output logic trig_burg, // Burglary / audible panic trigger
  output logic trig_silent, // Silent panic / duress trigger
  output logic [NLINK-1:0] link_module_en // Link module addresses allowed
);
  import keyswitch_pkg::*;

  typedef struct packed {
    logic [1:0] aux_sel; // Aux output mode
    logic [2:0] snd_part; // Partition the sounder follows
    logic oc_rpt_en; // Open/close reporting enable
    logic [2:0] tamper_resp; // Tamper zone response type
    logic [NPART-1:0] trig_en; // Trigger enable per partition
    logic [NLINK-1:0] link_en; // Link addresses enabled
    arm_t arm; // Partition arm state
    logic alarm; // Alarm active on keyswitch partition
    logic silenced; // Alarm silenced, memory kept
    logic memory; // Alarm memory shown
    logic lockout; // Keyswitch disabled by tamper
    logic tmp_s1; // Tamper sync one
    logic tmp_s2; // Tamper sync two
    logic tmp_d; // Tamper previous level
    logic [NPART-1:0] fire_p; // Fire pending per partition
    logic [NPART-1:0] burg_p; // Burglary pending per partition
    logic silent; // Silent panic latched
    logic duress; // Duress pulse
    logic [NEV-1:0] ev; // Sticky events
    logic [NEV-1:0] mask; // Interrupt mask
    logic [31:0] fcnt; // Flash divider
    logic slow; // Slow flash phase
    logic fast; // Rapid flash phase
    logic [31:0] rcnt; // Detector reset pulse counter
    logic [NPART-1:0] snd_s1; // Sounder sync one
    logic [NPART-1:0] snd_s2; // Sounder sync two
    logic [NPART-1:0] bp_s1; // Beep sync one
    logic [NPART-1:0] bp_s2; // Beep sync two
    logic rdy_s1; // Ready sync one
    logic rdy_s2; // Ready sync two
    logic kp_off; // Keypad user code + off seen
    logic [31:0] rdata; // Read data
    logic wait_n; // Answer phase
    logic irq; // Interrupt out
    logic green; // Green LED
    logic red; // Red LED
    logic aux; // Aux output
    logic det_b; // Detector reset
    logic tf; // Fire trigger
    logic tb; // Burglary trigger
    logic ts; // Silent trigger
  } st_t;
  st_t s, next_s;

  logic brief; // Brief closure pulse
  logic held; // Held closure pulse

  // Zone dedicated to the keyswitch; no protection logic reads it
  closure_classifier #(
    .DEB(DEB),
    .HOLD_CYC(HOLD_CYC)
  ) u_cls (
    .mclk(mclk),
    .rst_b(rst_b),
    .contact_raw(keyswitch_in),
    .brief(brief),
    .held(held)
  );

  logic wr; // Write accepted this cycle
  logic rd; // Read first seen this cycle
  assign wr = avs_write && s.wait_n;
  // Data is registered with the answer, so it stands while waitrequest is low
  assign rd = avs_read && !s.wait_n;

  // Whole block next state
  always_comb begin
    logic [NEV-1:0] set; // Events this cycle
    logic [31:0] wd; // Write data masked by lanes
    logic kp_off; // Off entry strobe this cycle
    logic [NPART-1:0] fire_set; // New fire alarms
    logic [NPART-1:0] burg_set; // New burglary alarms
    logic [NPART-1:0] off_set; // Off entries per partition
    logic silent_set; // Silent panic asserted
    logic duress_set; // Duress asserted
    logic [NPART-1:0] snd; // Sounding without key beeps
    set = '0;
    wd = avs_writedata;
    kp_off = 1'b0;
    fire_set = '0;
    burg_set = '0;
    off_set = '0;
    silent_set = 1'b0;
    duress_set = 1'b0;
    snd = '0;
    next_s = s;
    for (int b = 0; b < 4; b++) begin
      if (!avs_byteenable[b]) begin
        wd[b*8 +: 8] = 8'h00;
      end
    end
    // Synchronisers for pins
    next_s.tmp_s1 = tamper_in;
    next_s.tmp_s2 = s.tmp_s1;
    next_s.tmp_d = s.tmp_s2;
    next_s.snd_s1 = keypad_sound;
    next_s.snd_s2 = s.snd_s1;
    next_s.bp_s1 = keypad_beep;
    next_s.bp_s2 = s.bp_s1;
    next_s.rdy_s1 = part_ready;
    next_s.rdy_s2 = s.rdy_s1;
    // Bus: one wait cycle, then answer
    next_s.wait_n = (avs_read || avs_write) && !s.wait_n;
    if (wr) begin
      unique case (avs_address)
        A_CTRL: begin
          next_s.aux_sel = wd[1:0];
          next_s.snd_part = wd[6:4];
          next_s.oc_rpt_en = wd[8];
          next_s.tamper_resp = wd[14:12];
        end
        A_TRIG_EN: next_s.trig_en = wd[NPART-1:0];
        A_LINK_EN: begin
          next_s.link_en = wd;
          next_s.link_en[0] = 1'b0;
          next_s.link_en[31] = 1'b0;
        end
        A_ALARM: begin
          fire_set = wd[7:0];
          burg_set = wd[15:8];
          silent_set = wd[16];
          duress_set = wd[17];
          next_s.alarm = s.alarm || wd[24];
        end
        A_IRQ_MASK: next_s.mask = wd[NEV-1:0];
        A_KEYPAD: begin
          off_set = wd[7:0];
          kp_off = wd[8];
        end
        default: begin
        end
      endcase
    end
    // Keyswitch commands, ignored under tamper lockout
    if (!s.lockout && (brief || held)) begin
      if (s.alarm) begin
        next_s.alarm = 1'b0;
        next_s.silenced = 1'b1;
        next_s.memory = 1'b1;
        set[EV_SILENCE] = 1'b1;
        if (s.arm != ARM_OFF) begin
          next_s.arm = ARM_OFF;
          set[EV_OPEN] = s.oc_rpt_en;
        end
      end else if (s.silenced || s.memory) begin
        next_s.silenced = 1'b0;
        next_s.memory = 1'b0;
        next_s.rcnt = 32'(RST_PULSE);
      end else if (s.arm != ARM_OFF) begin
        next_s.arm = ARM_OFF;
        set[EV_OPEN] = s.oc_rpt_en;
      end else if (held) begin
        next_s.arm = ARM_STAY;
        set[EV_CLOSE] = s.oc_rpt_en;
      end else begin
        next_s.arm = ARM_AWAY;
        set[EV_CLOSE] = s.oc_rpt_en;
      end
    end
    // Tamper opening raises alarm or trouble
    if (s.tmp_s2 && !s.tmp_d) begin
      next_s.lockout = 1'b1;
      if (s.tamper_resp == TAMPER_RESP_DAYNIGHT && s.arm == ARM_OFF) begin
        set[EV_TAMPER_TRBL] = 1'b1;
      end else begin
        set[EV_TAMPER_ALARM] = 1'b1;
        next_s.alarm = 1'b1;
      end
    end else if (s.lockout && !s.tmp_s2 && next_s.arm == ARM_OFF) begin
      next_s.lockout = 1'b0;
    end
    // Triggers: fire/burglary latch per partition, clear by off in that partition
    next_s.fire_p = (s.fire_p & ~off_set) | (fire_set & s.trig_en);
    next_s.burg_p = (s.burg_p & ~off_set) | (burg_set & s.trig_en);
    next_s.silent = s.silent || silent_set;
    next_s.duress = duress_set;
    next_s.tf = |next_s.fire_p;
    next_s.tb = |next_s.burg_p;
    next_s.ts = next_s.silent || next_s.duress;
    // Flash generator
    if (s.fcnt >= 32'(SLOW_FLASH - 1)) begin
      next_s.fcnt = '0;
      next_s.slow = !s.slow;
    end else begin
      next_s.fcnt = s.fcnt + 32'h1;
    end
    if ((s.fcnt % 32'(FAST_FLASH)) == 32'(FAST_FLASH - 1)) begin
      next_s.fast = !s.fast;
    end
    // Indicators
    next_s.green = (s.arm == ARM_OFF) && !s.memory && s.rdy_s2;
    if (s.memory) begin
      next_s.red = s.fast;
    end else begin
      unique case (s.arm)
        ARM_AWAY: next_s.red = 1'b1;
        ARM_STAY: next_s.red = s.slow;
        default: next_s.red = 1'b0;
      endcase
    end
    // Detector reset pulse
    if (s.rcnt != '0) begin
      next_s.rcnt = s.rcnt - 32'h1;
    end
    next_s.det_b = (next_s.rcnt == '0);
    // General-purpose output
    snd = s.snd_s2 & ~s.bp_s2;
    if (kp_off) begin
      next_s.kp_off = 1'b1;
    end else if (!wr) begin
      next_s.kp_off = 1'b0;
    end
    if (s.aux_sel == AUX_SEL_SOUNDER) begin
      next_s.aux = snd[s.snd_part];
    end else if (s.aux_sel == AUX_SEL_RESET) begin
      next_s.aux = !s.kp_off;
    end else begin
      next_s.aux = 1'b0;
    end
    // Sticky events, set wins over clear
    next_s.ev = s.ev;
    if (wr && avs_address == A_IRQ_ST) begin
      next_s.ev = s.ev & ~wd[NEV-1:0];
    end
    next_s.ev = next_s.ev | set;
    next_s.irq = |(next_s.ev & next_s.mask);
    // Read data
    next_s.rdata = '0;
    if (rd) begin
      unique case (avs_address)
        A_CTRL: next_s.rdata = {17'h00000, s.tamper_resp, 3'h0, s.oc_rpt_en, 1'b0,
          s.snd_part, 2'h0, s.aux_sel};
        A_TRIG_EN: next_s.rdata = {24'h000000, s.trig_en};
        A_LINK_EN: next_s.rdata = s.link_en;
        A_ALARM: next_s.rdata = {29'h00000000, s.ts, s.tb, s.tf};
        A_STATUS: next_s.rdata = {24'h000000, s.lockout, s.memory, s.silenced,
          s.alarm, 2'h0, s.arm};
        A_IRQ_ST: next_s.rdata = {27'h0000000, s.ev};
        A_IRQ_MASK: next_s.rdata = {27'h0000000, s.mask};
        default: next_s.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= '0;
      s.det_b <= 1'b1;
      s.aux <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs from flops
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = !s.wait_n;
  assign irq = s.irq;
  assign led_green = s.green;
  assign led_red = s.red;
  assign aux_out = s.aux;
  assign detector_reset_b = s.det_b;
  assign trig_fire = s.tf;
  assign trig_burg = s.tb;
  assign trig_silent = s.ts;
  assign link_module_en = s.link_en;

  // Brief closure when idle arms away
  property p_away;
    @(posedge mclk) disable iff (!rst_b)
      (brief && !s.lockout && !s.alarm && !s.silenced && !s.memory && s.arm == ARM_OFF)
      |=> s.arm == ARM_AWAY;
  endproperty
  a_away: assert property (p_away) else $error("brief closure did not arm away");

  // Held closure when idle arms stay
  property p_stay;
    @(posedge mclk) disable iff (!rst_b)
      (held && !s.lockout && !s.alarm && !s.silenced && !s.memory && s.arm == ARM_OFF)
      |=> s.arm == ARM_STAY;
  endproperty
  a_stay: assert property (p_stay) else $error("held closure did not arm stay");

  // Closure when armed disarms
  property p_disarm;
    @(posedge mclk) disable iff (!rst_b)
      ((brief || held) && !s.lockout && s.arm != ARM_OFF) |=> s.arm == ARM_OFF;
  endproperty
  a_disarm: assert property (p_disarm) else $error("closure did not disarm");

  // Alarm closure silences
  property p_silence;
    @(posedge mclk) disable iff (!rst_b)
      ((brief || held) && !s.lockout && s.alarm) |=> (s.silenced && !s.alarm);
  endproperty
  a_silence: assert property (p_silence) else $error("alarm not silenced");

  // Lockout blocks arming
  property p_lock;
    @(posedge mclk) disable iff (!rst_b)
      (s.lockout && s.arm == ARM_OFF && !$past(wr)) |=> s.arm == ARM_OFF;
  endproperty
  a_lock: assert property (p_lock) else $error("keyswitch acted under lockout");

  // Away shows steady red after two cycles
  property p_led;
    @(posedge mclk) disable iff (!rst_b)
      (s.arm == ARM_AWAY && !s.memory)[*2] |=> (led_red && !led_green);
  endproperty
  a_led: assert property (p_led) else $error("away indication wrong");

  // Fire trigger holds without off entry
  property p_fire;
    @(posedge mclk) disable iff (!rst_b)
      (trig_fire && !(wr && avs_address == A_KEYPAD)) |=> trig_fire;
  endproperty
  a_fire: assert property (p_fire) else $error("fire trigger dropped early");

  // Duress pulse lasts one cycle
  property p_duress;
    @(posedge mclk) disable iff (!rst_b)
      (s.duress && !s.silent) |=> (!s.duress || $past(wr));
  endproperty
  a_duress: assert property (p_duress) else $error("duress pulse too long");
endmodule // keyswitch_ctrl

// File: inc/keyswitch_pkg.sv
// Functional notes
// - Keyswitch zone serves one partition only
// - Brief closure while disarmed arms away
// - Closure held past ten seconds arms stay
// - Closure while armed disarms the partition
// - Closure in alarm silences and disarms
// - Next closure clears memory, pulses detector reset
// - Green/red indicators show partition status
// - Keyswitch open/close reported as user 0
// - Tamper alarms or troubles, locks keyswitch out
// - Tamper type 5: trouble disarmed, alarm armed
// - Detector reset output idles high, low on off
// - Sounder mode copies keypad sounds except key beeps
// - Sounder follows chosen partition, select value 2
// - Triggers shared, fire/burglary gated by per-partition enable
// - Fire/burglary triggers latch until off in each partition holding one
// - Silent panic latches, duress pulses once
// - No link traffic until module address enabled
package keyswitch_pkg;
  localparam int NPART = 8; // Partitions
  localparam int NLINK = 32; // Link module address space
  localparam int CLK_HZ = 250000000; // mclk rate
  localparam int HOLD_S = 10; // Stay-arm hold time in seconds
  localparam longint HOLD_CYC_DEF = longint'(HOLD_S) * CLK_HZ; // Too big for a signed int
  localparam int DEB_MS = 20; // Debounce time in ms
  localparam int DEB_CYC = DEB_MS * (CLK_HZ / 1000); // Debounce in cycles
  localparam int SLOW_FLASH_DEF = CLK_HZ / 2; // Half period of slow flash
  localparam int FAST_FLASH_DEF = CLK_HZ / 8; // Half period of rapid flash
  localparam int RST_PULSE_DEF = CLK_HZ * 4; // Detector reset pulse
  localparam logic [2:0] TAMPER_RESP_DAYNIGHT = 3'h5; // Day trouble / night alarm
  localparam logic [1:0] AUX_SEL_RESET = 2'h1; // Output used for detector reset
  localparam logic [1:0] AUX_SEL_SOUNDER = 2'h2; // Output mirrors keypad sounder
  localparam logic [4:0] LINK_ADDR_MIN = 5'h01; // Lowest link module address
  localparam logic [4:0] LINK_ADDR_MAX = 5'h1E; // Highest link module address
  // Avalon register byte addresses
  localparam logic [5:0] A_CTRL = 6'h00; // Aux select, sounder partition, open/close reporting, tamper type
  localparam logic [5:0] A_TRIG_EN = 6'h04; // Per-partition trigger enable
  localparam logic [5:0] A_LINK_EN = 6'h08; // Enabled link module addresses
  localparam logic [5:0] A_ALARM = 6'h0C; // Write: alarm events, read: trigger state
  localparam logic [5:0] A_STATUS = 6'h10; // Arm state, alarm, silenced, memory, tamper lockout
  localparam logic [5:0] A_IRQ_ST = 6'h14; // Sticky events, write one to clear
  localparam logic [5:0] A_IRQ_MASK = 6'h18; // Interrupt mask
  localparam logic [5:0] A_KEYPAD = 6'h1C; // Keypad off entries per partition, code plus off strobe
  // Interrupt status bits
  localparam int EV_OPEN = 0; // Keyswitch disarm report
  localparam int EV_CLOSE = 1; // Keyswitch arm report
  localparam int EV_TAMPER_ALARM = 2; // Tamper alarm
  localparam int EV_TAMPER_TRBL = 3; // Tamper trouble
  localparam int EV_SILENCE = 4; // Alarm silenced
  localparam int NEV = 5; // Event count
  typedef enum logic [1:0] {
    ARM_OFF = 2'b00,
    ARM_AWAY = 2'b01,
    ARM_STAY = 2'b10
  } arm_t;
endpackage

// File: hdl/closure_classifier.sv
`timescale 1ns/1ps
// Debounced contact closure, sorted into brief or held
module closure_classifier
  import keyswitch_pkg::*;
#(
  parameter int DEB = DEB_CYC, // Debounce length, shortened in sim
  parameter longint HOLD_CYC = HOLD_CYC_DEF // Hold threshold, shortened in sim
) (
  input wire logic mclk, // Clock
  input wire logic rst_b, // Sync reset, active low
  input wire logic contact_raw, // Contact pin, high when shorted
  output logic brief, // Pulse: brief closure ended
  output logic held // Pulse: hold time reached
);
  import keyswitch_pkg::*;
  typedef struct packed {
    logic s1; // Sync stage one
    logic s2; // Sync stage two
    logic deb; // Debounced level
    logic [31:0] dcnt; // Debounce counter
    logic [31:0] hcnt; // Hold counter
    logic done; // Closure already classified as held
    logic brief; // Brief pulse
    logic held; // Held pulse
  } st_t;
  st_t s, next_s;

  // Debounce, then time the closure
  always_comb begin
    next_s = s;
    next_s.s1 = contact_raw;
    next_s.s2 = s.s1;
    next_s.brief = 1'b0;
    next_s.held = 1'b0;
    if (s.s2 != s.deb) begin
      // Level must hold steady to be believed
      if (s.dcnt >= 32'(DEB - 1)) begin
        next_s.deb = s.s2;
        next_s.dcnt = '0;
      end else begin
        next_s.dcnt = s.dcnt + 32'h1;
      end
    end else begin
      next_s.dcnt = '0;
    end
    if (s.deb) begin
      if (!s.done) begin
        if (s.hcnt >= 32'(HOLD_CYC - 1)) begin
          next_s.held = 1'b1;
          next_s.done = 1'b1;
        end else begin
          next_s.hcnt = s.hcnt + 32'h1;
        end
      end
      if (next_s.deb == 1'b0) begin
        // Release before hold expiry counts as brief
        next_s.brief = !s.done && !next_s.held;
        next_s.hcnt = '0;
        next_s.done = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign brief = s.brief;
  assign held = s.held;
endmodule // closure_classifier

// File: tb/keyswitch_far.sv
`timescale 1ns/1ps
// Far side: keyswitch contact, tamper switch, keypad sounders, one link module
module keyswitch_far
#(
  parameter logic [4:0] LINK_ADDR = 5'h07 // Own link address, unique in 01..30
) (
  input wire logic mclk, // Clock
  input wire logic [keyswitch_pkg::NPART-1:0] snd_cmd, // Sound levels from bench
  input wire logic [keyswitch_pkg::NPART-1:0] beep_cmd, // Key beeps from bench
  input wire logic tamper_cmd, // Bench lifts keyswitch off wall
  input wire logic key_cmd, // Bench turns the key
  input wire logic [keyswitch_pkg::NLINK-1:0] link_module_en, // Enabled addresses
  output logic keyswitch_in, // Contact, high shorted
  output logic tamper_in, // Tamper, high open
  output logic [keyswitch_pkg::NPART-1:0] keypad_sound, // Sounder levels
  output logic [keyswitch_pkg::NPART-1:0] keypad_beep, // Beep levels
  output logic link_talks // Link module allowed onto the bus
);
  import keyswitch_pkg::*;
  // Pins change only just after an edge
  always_ff @(posedge mclk) begin
    keyswitch_in <= key_cmd; // Contact follows the key, no bounce
    tamper_in <= tamper_cmd;
    keypad_sound <= snd_cmd;
    keypad_beep <= beep_cmd;
  end
  // Module stays silent until its address is enabled
  assign link_talks = link_module_en[LINK_ADDR];
endmodule // keyswitch_far

// File: tb/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the keyswitch controller
module tb;
  import keyswitch_pkg::*;
  logic mclk = 1'b0; // 250 MHz clock
  logic rst_b = 1'b0; // Sync reset, active low
  logic [5:0] avs_address = 6'h00; // Bus address
  logic avs_read = 1'b0; // Read request
  logic avs_write = 1'b0; // Write request
  logic [31:0] avs_writedata = 32'h0; // Write data
  logic [3:0] avs_byteenable = 4'hF; // All lanes used
  logic [31:0] avs_readdata; // Read data
  logic avs_waitrequest; // Stall
  logic irq; // Interrupt
  logic keyswitch_in; // Contact pin
  logic tamper_in; // Tamper pin
  logic part_ready = 1'b1; // Partition ready
  logic tamper_cmd = 1'b0; // Tamper request to partner
  logic key_cmd = 1'b0; // Contact request to partner
  logic [NPART-1:0] snd_cmd = '0; // Sound request to partner
  logic [NPART-1:0] beep_cmd = '0; // Beep request to partner
  logic [NPART-1:0] keypad_sound; // Sounder levels
  logic [NPART-1:0] keypad_beep; // Beep levels
  logic led_green, led_red, aux_out, detector_reset_b; // Indicators and outputs
  logic trig_fire, trig_burg, trig_silent; // Trigger header
  logic [NLINK-1:0] link_module_en; // Link enables
  logic link_talks; // Partner link module active
  int n_errors = 0; // Mismatches
  int comparisons = 0; // Checks made
  integer seed = 32'hEDCE78F6; // Fixed seed
  logic [31:0] rd; // Last read data
  logic [31:0] d; // Scratch word
  logic [7:0] en, pf, pb, o; // Enables, pending alarms, off entries
  logic hit; // Level seen in window

  // Clock
  always #2 mclk = ~mclk;

  keyswitch_ctrl #(.DEB(4), .HOLD_CYC(200), .SLOW_FLASH(16), .FAST_FLASH(4), .RST_PULSE(8))
  i_dut (
    .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .keyswitch_in(keyswitch_in), .tamper_in(tamper_in), .part_ready(part_ready),
    .keypad_sound(keypad_sound), .keypad_beep(keypad_beep), .led_green(led_green),
    .led_red(led_red), .aux_out(aux_out), .detector_reset_b(detector_reset_b),
    .trig_fire(trig_fire), .trig_burg(trig_burg), .trig_silent(trig_silent),
    .link_module_en(link_module_en));

  keyswitch_far i_far (
    .mclk(mclk), .snd_cmd(snd_cmd), .beep_cmd(beep_cmd), .tamper_cmd(tamper_cmd),
    .key_cmd(key_cmd),
    .link_module_en(link_module_en), .keyswitch_in(keyswitch_in), .tamper_in(tamper_in),
    .keypad_sound(keypad_sound), .keypad_beep(keypad_beep), .link_talks(link_talks));

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int i;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      chk("bus_answer", 32'h0, 32'h1);
      wrap_up();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Watch aux_out (0), trig_silent (1) or detector_reset_b (2) over a window
  task automatic seek(input int which, input logic lvl);
    hit = 1'b0;
    repeat (40) begin
      @(posedge mclk);
      if ((which == 0 ? aux_out : which == 1 ? trig_silent : detector_reset_b) === lvl) hit = 1'b1;
    end
  endtask

  // Close the contact for n cycles, then let it settle open
  task automatic press(input int n);
    key_cmd <= 1'b1;
    cyc(n);
    key_cmd <= 1'b0;
    cyc(24);
  endtask

  // Hang guard
  initial begin
    cyc(100000);
    chk("timeout", 32'h0, 32'h1);
    wrap_up();
  end

  // Main sequence
  initial begin
    cyc(15);
    chk("trig_rst", {trig_fire, trig_burg, trig_silent}, 32'h0);
    chk("det_rst", detector_reset_b, 32'h1);
    cyc(1);
    rst_b <= 1'b1;
    cyc(8);
    chk("led_ready", {led_green, led_red}, 32'h2);
    part_ready <= 1'b0;
    cyc(8);
    chk("led_notready", {led_green, led_red}, 32'h0);
    part_ready <= 1'b1;
    bus(0, A_STATUS, 32'h0);
    chk("status_rst", rd[7:0], 32'h0);
    bus(1, 6'h20, 32'h5A5A_5A5A);
    bus(0, 6'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    // Link enables, all-ones corner first
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 32'hFFFF_FFFF : 32'($random(seed));
      bus(1, A_LINK_EN, d);
      cyc(2);
      chk("link_en", link_module_en, d & 32'h7FFF_FFFE);
      chk("link_talks", link_talks, d[7]);
    end
    // Shared triggers, cleared only by off in every partition with a pending alarm
    for (int k = 0; k < 6; k++) begin
      en = (k == 0) ? 8'hFF : 8'($random(seed));
      pf = 8'($random(seed));
      pb = 8'($random(seed));
      bus(1, A_TRIG_EN, {24'h0, en});
      bus(1, A_ALARM, {16'h0, pb, pf});
      pf &= en;
      pb &= en;
      repeat (3) begin
        cyc(4);
        chk("trig_fire", trig_fire, |pf);
        chk("trig_burg", trig_burg, |pb);
        bus(0, A_ALARM, 32'h0);
        chk("alarm_rd", rd[1:0], {|pb, |pf});
        o = 8'($random(seed));
        bus(1, A_KEYPAD, {24'h0, o});
        pf &= ~o;
        pb &= ~o;
      end
      bus(1, A_KEYPAD, 32'h0000_00FF);
    end
    cyc(4);
    chk("trig_clear", {trig_fire, trig_burg}, 32'h0);
    // Duress pulses, silent panic latches through off
    bus(1, A_TRIG_EN, 32'h0000_00FF);
    bus(1, A_ALARM, 32'h0002_0000);
    seek(1, 1'b1);
    chk("duress_seen", hit, 32'h1);
    chk("duress_end", trig_silent, 32'h0);
    bus(1, A_ALARM, 32'h0001_0000);
    cyc(30);
    bus(1, A_KEYPAD, 32'h0000_00FF);
    cyc(4);
    chk("silent_latch", trig_silent, 32'h1);
    // Detector reset mode: idles high, dips on code plus off
    bus(1, A_CTRL, 32'(AUX_SEL_RESET));
    cyc(4);
    chk("aux_idle", aux_out, 32'h1);
    bus(1, A_KEYPAD, 32'h0000_0100);
    seek(0, 1'b0);
    chk("aux_dip", hit, 32'h1);
    chk("aux_back", aux_out, 32'h1);
    // Keyswitch: brief arms away, next disarms, long hold arms stay
    bus(1, A_CTRL, 32'h0000_0100);
    bus(1, A_IRQ_ST, 32'h1F);
    press(20);
    bus(0, A_STATUS, 32'h0);
    chk("arm_away", rd[1:0], 32'(ARM_AWAY));
    chk("red_away", {led_green, led_red}, 32'h1);
    bus(0, A_IRQ_ST, 32'h0);
    chk("close_rpt", rd[4:0], 32'h02);
    press(20);
    bus(0, A_STATUS, 32'h0);
    chk("disarm", rd[1:0], 32'(ARM_OFF));
    press(300);
    bus(0, A_STATUS, 32'h0);
    chk("arm_stay", rd[1:0], 32'(ARM_STAY));
    press(20);
    press(20);
    // Alarm while armed: closure silences and disarms, next clears memory
    bus(1, A_ALARM, 32'h0100_0000);
    bus(1, A_IRQ_ST, 32'h1F);
    press(20);
    bus(0, A_STATUS, 32'h0);
    chk("silence", rd[7:0], 32'h60);
    bus(0, A_IRQ_ST, 32'h0);
    chk("silence_ev", rd[4:0], 32'h11);
    key_cmd <= 1'b1;
    cyc(20);
    key_cmd <= 1'b0;
    seek(2, 1'b0);
    chk("det_pulse", hit, 32'h1);
    chk("det_back", detector_reset_b, 32'h1);
    bus(0, A_STATUS, 32'h0);
    chk("mem_clear", rd[7:0], 32'h00);
    // Sounder mode, every partition, beeps left out
    for (int p = 0; p < NPART; p++) begin
      bus(1, A_CTRL, (32'h5 << 12) | (32'(p) << 4) | 32'(AUX_SEL_SOUNDER));
      repeat (4) begin
        snd_cmd <= 8'($random(seed));
        beep_cmd <= 8'($random(seed));
        cyc(10);
        chk("sounder", aux_out, snd_cmd[p] & ~beep_cmd[p]);
      end
    end
    // Tamper while disarmed: trouble, lockout, masked then unmasked irq
    bus(1, A_IRQ_MASK, 32'h0);
    bus(1, A_IRQ_ST, 32'h1F);
    tamper_cmd <= 1'b1;
    cyc(30);
    chk("irq_masked", irq, 32'h0);
    bus(0, A_IRQ_ST, 32'h0);
    chk("tamper_ev", rd[3:2], 32'h2);
    press(20);
    bus(0, A_STATUS, 32'h0);
    chk("lockout_on", rd[7], 32'h1);
    chk("lock_arm", rd[1:0], 32'h0);
    bus(1, A_IRQ_MASK, 32'h1 << EV_TAMPER_TRBL);
    cyc(4);
    chk("irq_on", irq, 32'h1);
    tamper_cmd <= 1'b0;
    cyc(30);
    bus(1, A_IRQ_ST, 32'h08);
    cyc(4);
    chk("irq_off", irq, 32'h0);
    bus(0, A_STATUS, 32'h0);
    chk("lockout_off", rd[7], 32'h0);
    wrap_up();
  end
endmodule // tb
